// file: dv/tb_top.sv
// Self-checking bench of the separation voltage ramp
`timescale 1ns/1ps
`default_nettype none
`include "vfsvr_map.vh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
  $display("mismatch t=%0t got %0h exp %0h", $time, (a), (e)); end end
module tb_top;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] analogue_input_one, multistep_command, sequencer_pct, pid_pct, comm_pct;
  logic [15:0] output_voltage;
  logic pulse_capable_digital_input, output_ramping, osc_suppress_en_r;
  logic [6:0] oscillation_suppression_gain_r;
  int failures = 0, total_checks = 0, cyc = 0;
  int pct[9] = '{0, 2500, 0, 0, 10, 5000, 7500, 10000, 1000};
  // 100 MHz clock
  always #5 aclk = ~aclk;
  // Short counts keep the ramps within a few hundred cycles
  vfsvr_top #(.TENTH_CYCLES(10), .PULSE_WIN_CYCLES(1000)) dut (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .analogue_input_one, .multistep_command,
    .sequencer_pct, .pid_pct, .comm_pct, .pulse_capable_digital_input,
    .output_voltage, .output_ramping, .oscillation_suppression_gain_r, .osc_suppress_en_r);
  vfsvr_src_model #(.PERIOD(1000)) u_src (.aclk, .aresetn, .ain(analogue_input_one),
    .ms(multistep_command), .seq(sequencer_pct), .pid(pid_pct), .comm(comm_pct),
    .pulse(pulse_capable_digital_input));
  // Write: address and data together, response accepted after lag cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er,
                    input int lag);
    int n;
    logic done;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      done = s_axi_bvalid && s_axi_bready;
      n++;
      if (!done && n >= lag) s_axi_bready <= 1'b1;
    end while (!done);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
  endtask
  // Read and compare, data accepted after lag cycles
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
                    input int lag);
    int n;
    logic done;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      done = s_axi_rvalid && s_axi_rready;
      n++;
      if (!done && n >= lag) s_axi_rready <= 1'b1;
    end while (!done);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rresp, er)
    `CHK(s_axi_rdata, ed)
  endtask
  // Count cycles until the output reaches a value
  task automatic wait_v(input logic [15:0] v, output int n);
    n = 0;
    while (output_voltage !== v) begin
      @(posedge aclk);
      n++;
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      test_done();
    end
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    int n;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, clamps and refusals
    rd(`VFSVR_OFF_SRC, 32'h0000_0000, 2'b00, 0);
    rd(`VFSVR_OFF_DIG, 32'h0000_0000, 2'b00, 2);
    rd(`VFSVR_OFF_RISE, 32'h0000_0032, 2'b00, 0);
    rd(`VFSVR_OFF_FALL, 32'h0000_0032, 2'b00, 0);
    rd(`VFSVR_OFF_OSC, 32'h0000_0000, 2'b00, 0);
    rd(8'h40, 32'h0000_0000, 2'b10, 0);
    wr(`VFSVR_OFF_VOUT, 32'h0000_0001, 2'b10, 3);
    wr(`VFSVR_OFF_RISE, 32'h0000_FFFF, 2'b00, 0);
    rd(`VFSVR_OFF_RISE, 32'h0000_2710, 2'b00, 0);
    wr(`VFSVR_OFF_OSC, 32'h0000_00C8, 2'b00, 1);
    rd(`VFSVR_OFF_OSC, 32'h0000_0064, 2'b00, 0);
    `CHK(osc_suppress_en_r, 1'b1)
    wr(`VFSVR_OFF_OSC, 32'h0000_0000, 2'b00, 0);
    repeat (2) @(posedge aclk);
    `CHK(osc_suppress_en_r, 1'b0)
    $display("test map done");
    // Selector codes 0 to 8, with zero slope times so the output steps
    wr(`VFSVR_OFF_RISE, 32'h0000_0000, 2'b00, 0);
    wr(`VFSVR_OFF_FALL, 32'h0000_0000, 2'b00, 0);
    wr(`VFSVR_OFF_DIG, 32'h0000_0123, 2'b00, 0);
    repeat (3000) @(posedge aclk);
    rd(`VFSVR_OFF_PULSE, 32'h0000_000A, 2'b00, 0);
    for (int c = 0; c < 9; c++) begin
      wr(`VFSVR_OFF_SRC, 32'(c), 2'b00, 0);
      repeat (3) @(posedge aclk);
      rd(`VFSVR_OFF_TGT, c == 0 ? 32'h0000_0123 : 32'(pct[c] * 3840 / 10000), 2'b00, c % 3);
      `CHK(output_voltage, c == 0 ? 16'h0123 : 16'(pct[c] * 3840 / 10000))
    end
    $display("test sources done");
    // Full rise over 20 tenths, partial fall over 10 tenths
    wr(`VFSVR_OFF_SRC, 32'h0000_0000, 2'b00, 0);
    wr(`VFSVR_OFF_DIG, 32'h0000_0000, 2'b00, 0);
    wr(`VFSVR_OFF_RATED, 32'h0000_0064, 2'b00, 0);
    wr(`VFSVR_OFF_RISE, 32'h0000_0014, 2'b00, 0);
    wr(`VFSVR_OFF_FALL, 32'h0000_000A, 2'b00, 0);
    wr(`VFSVR_OFF_DIG, 32'h0000_0064, 2'b00, 0);
    repeat (50) @(posedge aclk);
    `CHK(output_ramping, 1'b1)
    `CHK(output_voltage >= 16'h0014 && output_voltage <= 16'h001E, 1'b1)
    wait_v(16'h0064, n);
    `CHK(n >= 140 && n <= 160, 1'b1)
    repeat (4) @(posedge aclk);
    `CHK(output_ramping, 1'b0)
    wr(`VFSVR_OFF_DIG, 32'h0000_0028, 2'b00, 0);
    wait_v(16'h0028, n);
    `CHK(n >= 55 && n <= 70, 1'b1)
    $display("test ramp done");
    test_done();
  end
endmodule // tb_top
bind vfsvr_top vfsvr_asserts u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .oscillation_suppression_gain_r, .osc_suppress_en_r);
`default_nettype wire

// file: dv/vfsvr_asserts.sv
// Port checker of the separation voltage ramp
`timescale 1ns/1ps
`default_nettype none
module vfsvr_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Modulation stage
  input wire logic [6:0] oscillation_suppression_gain_r,
  input wire logic osc_suppress_en_r
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Address and data taken on the same edge
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Take edge, then the held pair fires the response one edge later
  a_write_resp: assert property (s_wr_take |=> ##1 s_axi_bvalid)
    else $error("write response not two cycles after take");
  a_read_resp: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not one cycle after take");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_ro_write_err: assert property ((s_wr_take and (s_axi_awaddr >= 8'h18)) |=> ##1
    s_axi_bresp == 2'b10)
    else $error("write to read-only place not refused");
  a_rw_write_ok: assert property ((s_wr_take and (s_axi_awaddr < 8'h18)) |=> ##1
    s_axi_bresp == 2'b00)
    else $error("write to register refused");
  a_gain_limit: assert property (oscillation_suppression_gain_r <= 7'h64)
    else $error("gain above limit");
  a_gain_enable: assert property ($changed(oscillation_suppression_gain_r) |=>
    osc_suppress_en_r == ($past(oscillation_suppression_gain_r) != 7'h00))
    else $error("suppression enable wrong");
  c_slow_read: cover property (s_axi_rvalid && !s_axi_rready);
endmodule // vfsvr_asserts
`default_nettype wire

// file: dv/vfsvr_src_model.sv
// Model of the setpoint sources and the external pulse generator
`timescale 1ns/1ps
`default_nettype none
module vfsvr_src_model #(
  parameter PERIOD = 1000
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Percentage sources, 0.01 % per LSB
  output logic [15:0] ain,
  output logic [15:0] ms,
  output logic [15:0] seq,
  output logic [15:0] pid,
  output logic [15:0] comm,
  // Pulse pin
  output logic pulse
);
  int cnt;
  // Fixed levels; comm is negative to exercise the magnitude path
  assign ain = 16'h09C4;
  assign ms = 16'h1388;
  assign seq = 16'h1D4C;
  assign pid = 16'h2710;
  assign comm = 16'hFC18;
  // One rising edge per PERIOD cycles, so never above 100 kHz
  always @(posedge aclk) begin
    if (!aresetn || cnt == PERIOD - 1) cnt <= 0;
    else cnt <= cnt + 1;
    pulse <= (cnt < PERIOD / 2);
  end
endmodule // vfsvr_src_model
`default_nettype wire

// file: hw/vfsvr_map.vh
// Register map, reset values and timing constants of the separation voltage ramp
`ifndef VFSVR_MAP_VH
`define VFSVR_MAP_VH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define VFSVR_OFF_SRC 8'h00
`define VFSVR_OFF_DIG 8'h04
`define VFSVR_OFF_RATED 8'h08
`define VFSVR_OFF_RISE 8'h0C
`define VFSVR_OFF_FALL 8'h10
`define VFSVR_OFF_OSC 8'h14
`define VFSVR_OFF_VOUT 8'h18
`define VFSVR_OFF_TGT 8'h1C
`define VFSVR_OFF_PULSE 8'h20
// ****************************************************************
// Reset values
// ****************************************************************
`define VFSVR_RST_SRC 4'h0
`define VFSVR_RST_DIG 16'h0000
`define VFSVR_RST_RATED 16'h0F00
`define VFSVR_RST_TIME 14'h0032
`define VFSVR_RST_OSC 7'h00
// ****************************************************************
// Limits and codes
// ****************************************************************
`define VFSVR_TIME_MAX 14'h2710
`define VFSVR_OSC_MAX 7'h64
`define VFSVR_PCT_FULL 14'h2710
`define VFSVR_SRC_DIG 4'h0
`define VFSVR_SRC_AIN 4'h1
`define VFSVR_SRC_PULSE 4'h4
`define VFSVR_SRC_MSTEP 4'h5
`define VFSVR_SRC_SEQ 4'h6
`define VFSVR_SRC_PID 4'h7
`define VFSVR_SRC_COMM 4'h8
`define VFSVR_RESP_OK 2'b00
`define VFSVR_RESP_ERR 2'b10
// ****************************************************************
// Timing
// ****************************************************************
`define VFSVR_CLK_MHZ 100
`define VFSVR_TENTH_S_US 100000
`define VFSVR_PULSE_WIN_US 10000
`define VFSVR_PULSE_FULL_KHZ 100
`endif

// file: hw/vfsvr_ramp.v
// Slew limiter that moves the output voltage toward its setpoint
`timescale 1ns/1ps
`default_nettype none
module vfsvr_ramp #(
  parameter TENTH_CYCLES = 10000000
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Setpoint and slope settings
  input wire [15:0] target,
  input wire [15:0] rated,
  input wire [13:0] rise_time,
  input wire [13:0] fall_time,
  // Slewed voltage
  output reg [15:0] vout_r,
  output reg ramping_r
);
  localparam [31:0] TENTH_32 = TENTH_CYCLES;
  localparam [39:0] TENTH_W = {8'h00, TENTH_32};
  reg [39:0] acc_r;
  reg dir_up_r;
  wire up = (target > vout_r);
  wire [13:0] t_sel = up ? rise_time : fall_time;
  wire [39:0] den = {26'h00_0000_0, t_sel} * TENTH_W;
  wire [39:0] acc_sum = acc_r + {24'h00_0000, rated};
  // Fractional accumulator: one LSB each time the rated-volt sum crosses
  // the time budget, so full scale takes exactly the configured time
  always @(posedge aclk) begin
    if (!aresetn) begin
      vout_r <= 16'h0000;
      acc_r <= 40'h00_0000_0000;
      dir_up_r <= 1'b1;
      ramping_r <= 1'b0;
    end else begin
      dir_up_r <= up;
      ramping_r <= (vout_r != target);
      if (vout_r == target) begin
        acc_r <= 40'h00_0000_0000;
      end else if (t_sel == 14'h0000) begin
        vout_r <= target; // see RULE9
        acc_r <= 40'h00_0000_0000;
      end else if (up != dir_up_r) begin
        // Reversal restarts the fraction so the new slope starts clean
        acc_r <= 40'h00_0000_0000;
      end else if (acc_sum >= den) begin
        acc_r <= acc_sum - den;
        if (up) begin
          vout_r <= vout_r + 16'h0001; // see RULE5
        end else begin
          vout_r <= vout_r - 16'h0001; // see RULE6
        end
      end else begin
        acc_r <= acc_sum; // see RULE9
      end
    end
  end
endmodule // vfsvr_ramp
`default_nettype wire

// file: hw/vfsvr_top.v
// Separation voltage setpoint selection, scaling and slew with AXI4-Lite registers
//
// How it works
// RULE1: Selector code picks digital, analogue, pulse, multistep, sequencer, PID or comm source.
// RULE2: Digital code uses stored digital voltage, zero to rated, default zero.
// RULE3: Percent sources map zero to full scale linearly onto zero to rated voltage.
// RULE4: Negative percentage source values are used by their magnitude.
// RULE5: Rising voltage slope covers zero to rated in the rise time, default 5.0 s.
// RULE6: Falling voltage slope covers rated to zero in the fall time, default 5.0 s.
// RULE7: External pulse source on the pulse input stays between 0 and 100 kHz.
// RULE8: Oscillation suppression gain 0 to 100, zero disables, larger is stronger.
// RULE9: Partial changes use the same slope; zero time steps at once.
`timescale 1ns/1ps
`default_nettype none
`include "vfsvr_map.vh"
module vfsvr_top #(
  parameter TENTH_CYCLES = `VFSVR_CLK_MHZ * `VFSVR_TENTH_S_US,
  parameter PULSE_WIN_CYCLES = `VFSVR_CLK_MHZ * `VFSVR_PULSE_WIN_US
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address and data
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Percentage sources, signed, 16'h2710 is full scale
  input wire [15:0] analogue_input_one,
  input wire [15:0] multistep_command,
  input wire [15:0] sequencer_pct,
  input wire [15:0] pid_pct,
  input wire [15:0] comm_pct,
  // Pulse train pin
  input wire pulse_capable_digital_input,
  // Modulation stage
  output wire [15:0] output_voltage,
  output wire output_ramping,
  output reg [6:0] oscillation_suppression_gain_r,
  output reg osc_suppress_en_r
);
  // ****************************************************************
  // Setting registers
  // ****************************************************************
  reg [3:0] separation_voltage_source_select_r;
  reg [15:0] separation_voltage_digital_value_r;
  reg [15:0] rated_voltage_r;
  reg [13:0] separation_voltage_rise_time_r;
  reg [13:0] separation_voltage_fall_time_r;
  reg [15:0] target_r;
  reg [13:0] pulse_pct_r;
  wire [15:0] vout;
  wire ramping;

  // Byte-lane merge for a 16-bit register
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] d;
    input [3:0] strb;
    begin
      merge16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  // ****************************************************************
  // AXI4-Lite write path
  // ****************************************************************
  reg aw_got_r;
  reg w_got_r;
  reg [7:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  wire wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
  wire [15:0] wr16 = merge16(16'h0000, wdata_r, wstrb_r);
  wire wr_map = (awaddr_r == `VFSVR_OFF_SRC) || (awaddr_r == `VFSVR_OFF_DIG) ||
                (awaddr_r == `VFSVR_OFF_RATED) || (awaddr_r == `VFSVR_OFF_RISE) ||
                (awaddr_r == `VFSVR_OFF_FALL) || (awaddr_r == `VFSVR_OFF_OSC);
  // Address and data latched in either order; response once both are held
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `VFSVR_RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? `VFSVR_RESP_OK : `VFSVR_RESP_ERR;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Register updates; out-of-range rise time, fall time and gain values clamp to the top of their span
  always @(posedge aclk) begin
    if (!aresetn) begin
      separation_voltage_source_select_r <= `VFSVR_RST_SRC;
      separation_voltage_digital_value_r <= `VFSVR_RST_DIG; // see RULE2
      rated_voltage_r <= `VFSVR_RST_RATED;
      separation_voltage_rise_time_r <= `VFSVR_RST_TIME; // see RULE5
      separation_voltage_fall_time_r <= `VFSVR_RST_TIME; // see RULE6
      oscillation_suppression_gain_r <= `VFSVR_RST_OSC;
      osc_suppress_en_r <= 1'b0;
    end else begin
      osc_suppress_en_r <= (oscillation_suppression_gain_r != 7'h00); // see RULE8
      if (wr_go) begin
        case (awaddr_r)
          `VFSVR_OFF_SRC: begin
            if (wstrb_r[0]) begin
              separation_voltage_source_select_r <= wdata_r[3:0];
            end
          end
          `VFSVR_OFF_DIG: begin
            separation_voltage_digital_value_r <=
              merge16(separation_voltage_digital_value_r, wdata_r, wstrb_r);
          end
          `VFSVR_OFF_RATED: begin
            rated_voltage_r <= merge16(rated_voltage_r, wdata_r, wstrb_r);
          end
          `VFSVR_OFF_RISE: begin
            separation_voltage_rise_time_r <= (wr16[13:0] > `VFSVR_TIME_MAX ||
              wr16[15:14] != 2'b00) ? `VFSVR_TIME_MAX : wr16[13:0];
          end
          `VFSVR_OFF_FALL: begin
            separation_voltage_fall_time_r <= (wr16[13:0] > `VFSVR_TIME_MAX ||
              wr16[15:14] != 2'b00) ? `VFSVR_TIME_MAX : wr16[13:0];
          end
          `VFSVR_OFF_OSC: begin
            if (wstrb_r[0]) begin
              oscillation_suppression_gain_r <= (wdata_r[7:0] > {1'b0, `VFSVR_OSC_MAX}) ?
                `VFSVR_OSC_MAX : wdata_r[6:0]; // see RULE8
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read path
  // ****************************************************************
  reg [31:0] rd_mux;
  reg rd_map;
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_map = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `VFSVR_OFF_SRC: rd_mux[3:0] = separation_voltage_source_select_r;
      `VFSVR_OFF_DIG: rd_mux[15:0] = separation_voltage_digital_value_r;
      `VFSVR_OFF_RATED: rd_mux[15:0] = rated_voltage_r;
      `VFSVR_OFF_RISE: rd_mux[13:0] = separation_voltage_rise_time_r;
      `VFSVR_OFF_FALL: rd_mux[13:0] = separation_voltage_fall_time_r;
      `VFSVR_OFF_OSC: rd_mux[6:0] = oscillation_suppression_gain_r;
      `VFSVR_OFF_VOUT: rd_mux = {15'h0000, ramping, vout};
      `VFSVR_OFF_TGT: rd_mux[15:0] = target_r;
      `VFSVR_OFF_PULSE: rd_mux[13:0] = pulse_pct_r;
      default: rd_map = 1'b0;
    endcase
  end

  // One read in flight; arready drops until the data is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `VFSVR_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_map ? `VFSVR_RESP_OK : `VFSVR_RESP_ERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************************************
  // Pulse input frequency to percentage
  // ****************************************************************
  localparam [31:0] WIN_W = PULSE_WIN_CYCLES;
  localparam [31:0] EDGE_FULL_W = `VFSVR_PULSE_FULL_KHZ * (`VFSVR_PULSE_WIN_US / 1000);
  localparam [16:0] EDGE_FULL = EDGE_FULL_W[16:0];
  reg pin_meta_r;
  reg pin_sync_r;
  reg pin_prev_r;
  reg [31:0] win_cnt_r;
  reg [16:0] edge_cnt_r;
  wire [30:0] pct_wide = {14'h0000, edge_cnt_r} * {17'h0_0000, `VFSVR_PCT_FULL};
  wire [30:0] pct_div = pct_wide / {14'h0000, EDGE_FULL};
  // Two-flop synchroniser, then rising edges counted over a fixed window;
  // a window trades update rate against resolution at low frequency
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
      pin_prev_r <= 1'b0;
      win_cnt_r <= 32'h0000_0000;
      edge_cnt_r <= 17'h0_0000;
      pulse_pct_r <= 14'h0000;
    end else begin
      pin_meta_r <= pulse_capable_digital_input;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
      if (win_cnt_r >= WIN_W - 32'h0000_0001) begin
        win_cnt_r <= 32'h0000_0000;
        edge_cnt_r <= 17'h0_0000;
        // Above 100 kHz the source is out of spec; clamp to full scale
        pulse_pct_r <= (edge_cnt_r >= EDGE_FULL) ? `VFSVR_PCT_FULL : pct_div[13:0]; // see RULE7
      end else begin
        win_cnt_r <= win_cnt_r + 32'h0000_0001;
        if (pin_sync_r && !pin_prev_r && edge_cnt_r != 17'h1_FFFF) begin
          edge_cnt_r <= edge_cnt_r + 17'h0_0001;
        end
      end
    end
  end

  // ****************************************************************
  // Source selection and scaling
  // ****************************************************************
  reg [15:0] pct_sel;
  reg use_pct;
  always @* begin
    use_pct = 1'b1;
    pct_sel = 16'h0000;
    case (separation_voltage_source_select_r) // see RULE1
      `VFSVR_SRC_AIN: pct_sel = analogue_input_one;
      `VFSVR_SRC_PULSE: pct_sel = {2'b00, pulse_pct_r};
      `VFSVR_SRC_MSTEP: pct_sel = multistep_command;
      `VFSVR_SRC_SEQ: pct_sel = sequencer_pct;
      `VFSVR_SRC_PID: pct_sel = pid_pct;
      `VFSVR_SRC_COMM: pct_sel = comm_pct;
      default: use_pct = 1'b0; // Digital, reserved and unused codes
    endcase
  end
  wire [15:0] pct_abs = pct_sel[15] ? (16'h0000 - pct_sel) : pct_sel; // see RULE4
  wire [13:0] pct_clip = (pct_abs > {2'b00, `VFSVR_PCT_FULL}) ? `VFSVR_PCT_FULL : pct_abs[13:0];
  wire [29:0] v_wide = {16'h0000, pct_clip} * {14'h0000, rated_voltage_r};
  wire [29:0] v_scaled = v_wide / {16'h0000, `VFSVR_PCT_FULL};
  wire [15:0] dig_clip = (separation_voltage_digital_value_r > rated_voltage_r) ?
                         rated_voltage_r : separation_voltage_digital_value_r;
  // Registered setpoint keeps the divider out of the slew path
  always @(posedge aclk) begin
    if (!aresetn) begin
      target_r <= 16'h0000;
    end else if (use_pct) begin
      target_r <= v_scaled[15:0]; // see RULE3
    end else if (separation_voltage_source_select_r == `VFSVR_SRC_DIG) begin
      target_r <= dig_clip; // see RULE2
    end else begin
      target_r <= 16'h0000;
    end
  end

  // ****************************************************************
  // Slew limiter
  // ****************************************************************
  vfsvr_ramp #(
    .TENTH_CYCLES(TENTH_CYCLES)
  ) u_ramp (
    .aclk(aclk),
    .aresetn(aresetn),
    .target(target_r),
    .rated(rated_voltage_r),
    .rise_time(separation_voltage_rise_time_r),
    .fall_time(separation_voltage_fall_time_r),
    .vout_r(vout),
    .ramping_r(ramping)
  );
  assign output_voltage = vout;
  assign output_ramping = ramping;
endmodule // vfsvr_top
`default_nettype wire
